/* design/sfpb_device.sv */
`timescale 1ns/1ps
module sfpb_device #(
    parameter int PAGES = sfpb_pkg::PAGE_COUNT, // Pages in main array
    parameter int OP_WAIT_CYCLES = 64 // Self-timed settle after a pass
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic binaryPage, // 1: 256-byte pages, 0: 264-byte
    output logic statusBusy, // Self-timed operation pending or running
    sfpb_link_if.dev lnk // Serial link
);
    import sfpb_pkg::*;

    localparam int MEM_BYTES = PAGES * PAGE_BYTES_STD;
    localparam int MW = $clog2(MEM_BYTES);
    localparam int BW = $clog2(BUF_COUNT * PAGE_BYTES_STD);
    localparam int WW = $clog2(OP_WAIT_CYCLES + 1);

    // Storage: pages kept at a 264-byte stride in both modes
    logic [7:0] flash [0:MEM_BYTES-1];
    logic [7:0] bufMem [0:BUF_COUNT*PAGE_BYTES_STD-1];

    // ---------------- Link domain (serial clock) ----------------
    sfpb_link_e state_r;
    logic [6:0] shift_r;
    logic [2:0] bitCnt_r;
    logic [2:0] byteCnt_r;
    logic [8:0] offset_r;
    logic [PAGE_BITS-1:0] page_r;
    logic [7:0] outByte_r;
    logic misoO_r;
    logic misoOe_r;
    logic [7:0] op_r;
    logic [23:0] addr_r;
    logic cmdTog_r;
    logic binL1_r;
    logic binL_r;

    // Select high holds the link logic in reset: ends any frame
    wire linkRst_n = rst_n & ~lnk.csN;
    wire [7:0] inByte = {shift_r, lnk.mosi};
    wire byteDone = (bitCnt_r == LAST_BIT);
    wire [7:0] opSrc = (state_r == L_OPCODE) ? inByte : op_r;
    wire [23:0] addrFull = {addr_r[15:0], inByte};

    // Opcode decode on the byte in hand
    wire isPageRd = (opSrc == OP_PAGE_READ);
    wire isBufRd = (opSrc == OP_BUF1_READ_HI) | (opSrc == OP_BUF1_READ_LO)
        | (opSrc == OP_BUF2_READ_HI) | (opSrc == OP_BUF2_READ_LO);
    wire isBufWr = (opSrc == OP_BUF1_WRITE)
        | (opSrc == OP_BUF2_WRITE);
    wire isProgE = (opSrc == OP_BUF1_PROG_ERASE)
        | (opSrc == OP_BUF2_PROG_ERASE);
    wire isProg = (opSrc == OP_BUF1_PROG) | (opSrc == OP_BUF2_PROG);
    wire isErase = (opSrc == OP_PAGE_ERASE);
    wire isExec = isProgE | isProg | isErase;
    wire isKnown = isPageRd | isBufRd | isBufWr | isExec;
    wire bufSel = (opSrc == OP_BUF2_READ_HI) | (opSrc == OP_BUF2_READ_LO)
        | (opSrc == OP_BUF2_WRITE) | (opSrc == OP_BUF2_PROG_ERASE)
        | (opSrc == OP_BUF2_PROG);

    // Address split per page mode
    wire [PAGE_BITS-1:0] pageOfAddr = binL_r
        ? addrFull[PAGE_LSB_BIN +: PAGE_BITS]
        : addrFull[PAGE_LSB_STD +: PAGE_BITS];
    wire [8:0] offOfAddr = binL_r ? {1'b0, addrFull[7:0]}
        : addrFull[8:0];
    wire [8:0] lastOffL = binL_r ? LAST_OFF_BIN : LAST_OFF_STD;
    wire [8:0] nextOff = (offset_r == lastOffL) ? FIRST_OFF
        : 9'(offset_r + 9'h001);
    wire [2:0] dummyNeed = isPageRd ? PAGE_READ_DUMMY
        : BUF_READ_DUMMY;
    wire lastAddr = (byteCnt_r == 3'(ADDR_BYTES - 3'h1));
    wire lastDummy = (byteCnt_r == 3'(dummyNeed - 3'h1));

    // Read source: page read never touches the buffers
    wire [BW-1:0] bufIdxL = BW'(int'(bufSel) * PAGE_BYTES_STD
        + int'(offset_r));
    wire [MW-1:0] memIdxL = MW'(int'(page_r) * PAGE_BYTES_STD
        + int'(offset_r));
    wire [7:0] rdByte = isBufRd ? bufMem[bufIdxL]
        : flash[memIdxL];

    wire fireExec = (state_r == L_ADDR) & byteDone & lastAddr & isExec;
    wire bufWe = (state_r == L_WRITE) & byteDone;

    // Mode strap into the link domain
    always_ff @(posedge lnk.sck or negedge rst_n) begin
        if (!rst_n) begin
            binL1_r <= 1'b0;
            binL_r <= 1'b0;
        end else begin
            binL1_r <= binaryPage;
            binL_r <= binL1_r;
        end
    end

    // Bit and byte framing, sampled on rising edges
    always_ff @(posedge lnk.sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            shift_r <= 7'h00;
            bitCnt_r <= 3'h0;
        end else begin
            shift_r <= inByte[6:0];
            bitCnt_r <= 3'(bitCnt_r + 3'h1);
        end
    end

    // Command phase sequencing
    always_ff @(posedge lnk.sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            state_r <= L_OPCODE;
            byteCnt_r <= 3'h0;
            offset_r <= FIRST_OFF;
            page_r <= '0;
            outByte_r <= FILL_BYTE;
        end else if (byteDone) begin
            case (state_r)
                L_OPCODE: begin
                    byteCnt_r <= 3'h0;
                    state_r <= isKnown ? L_ADDR : L_IGNORE;
                end
                L_ADDR: begin
                    byteCnt_r <= 3'(byteCnt_r + 3'h1);
                    if (lastAddr) begin
                        byteCnt_r <= 3'h0;
                        offset_r <= offOfAddr;
                        page_r <= pageOfAddr;
                        if (isPageRd | isBufRd) begin
                            state_r <= L_DUMMY;
                        end else if (isBufWr) begin
                            state_r <= L_WRITE;
                        end else begin
                            state_r <= L_IGNORE;
                        end
                    end
                end
                L_DUMMY: begin
                    byteCnt_r <= 3'(byteCnt_r + 3'h1);
                    if (lastDummy) begin
                        state_r <= L_READ;
                        outByte_r <= rdByte;
                        offset_r <= nextOff;
                    end
                end
                L_READ: begin
                    outByte_r <= rdByte;
                    offset_r <= nextOff;
                end
                L_WRITE: begin
                    offset_r <= nextOff;
                end
                L_IGNORE: begin
                    state_r <= L_IGNORE;
                end
                default: begin
                    state_r <= L_IGNORE;
                end
            endcase
        end
    end

    // Command words outlive the frame for the engine to use
    always_ff @(posedge lnk.sck or negedge rst_n) begin
        if (!rst_n) begin
            op_r <= 8'h00;
            addr_r <= 24'h000000;
            cmdTog_r <= 1'b0;
        end else if (!lnk.csN && byteDone) begin
            if (state_r == L_OPCODE) begin
                op_r <= inByte;
            end
            if (state_r == L_ADDR) begin
                addr_r <= addrFull;
            end
            if (fireExec) begin
                cmdTog_r <= ~cmdTog_r;
            end
        end
    end

    // Buffer fill, no reset on storage
    always_ff @(posedge lnk.sck) begin
        if (bufWe && !lnk.csN) begin
            bufMem[bufIdxL] <= inByte;
        end
    end

    // Output bits change on falling edges, MSB first
    always_ff @(negedge lnk.sck or negedge linkRst_n) begin
        if (!linkRst_n) begin
            misoO_r <= 1'b0;
            misoOe_r <= 1'b0;
        end else begin
            misoO_r <= outByte_r[LAST_BIT - bitCnt_r];
            misoOe_r <= (state_r == L_READ);
        end
    end

    assign lnk.misoO = misoO_r;
    assign lnk.misoOe = misoOe_r;

    // ---------------- System domain (clock) ----------------
    sfpb_exec_e exec_r;
    logic csS1_r;
    logic csS_r;
    logic togS1_r;
    logic togS2_r;
    logic togS3_r;
    logic binS1_r;
    logic binS_r;
    logic pend_r;
    logic [7:0] xOp_r;
    logic [PAGE_BITS-1:0] xPage_r;
    logic [8:0] xCnt_r;
    logic [WW-1:0] wait_r;
    logic busy_r;

    // Toggle and level crossings from the link side
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            csS1_r <= 1'b1;
            csS_r <= 1'b1;
            togS1_r <= 1'b0;
            togS2_r <= 1'b0;
            togS3_r <= 1'b0;
            binS1_r <= 1'b0;
            binS_r <= 1'b0;
        end else begin
            csS1_r <= lnk.csN;
            csS_r <= csS1_r;
            togS1_r <= cmdTog_r;
            togS2_r <= togS1_r;
            togS3_r <= togS2_r;
            binS1_r <= binaryPage;
            binS_r <= binS1_r;
        end
    end

    wire cmdEvent = togS2_r ^ togS3_r;
    // Work starts only once select is back high
    wire startX = pend_r & csS_r & (exec_r == X_IDLE);
    wire xBuf2 = (xOp_r == OP_BUF2_PROG_ERASE) | (xOp_r == OP_BUF2_PROG);
    wire xHasErase = (xOp_r != OP_BUF1_PROG) & (xOp_r != OP_BUF2_PROG);
    wire xIsErase = (xOp_r == OP_PAGE_ERASE);
    wire [8:0] lastOffX = binS_r ? LAST_OFF_BIN : LAST_OFF_STD;
    wire passEnd = (xCnt_r == lastOffX);
    wire [PAGE_BITS-1:0] cmdPage = binS_r
        ? addr_r[PAGE_LSB_BIN +: PAGE_BITS]
        : addr_r[PAGE_LSB_STD +: PAGE_BITS];
    wire [MW-1:0] memIdxX = MW'(int'(xPage_r) * PAGE_BYTES_STD
        + int'(xCnt_r));
    wire [BW-1:0] bufIdxX = BW'(int'(xBuf2) * PAGE_BYTES_STD
        + int'(xCnt_r));
    wire flashWe = (exec_r == X_ERASE) | (exec_r == X_PROG);
    // Plain programming can only clear bits, so it ANDs in the data
    wire [7:0] progByte = xHasErase ? bufMem[bufIdxX]
        : (flash[memIdxX] & bufMem[bufIdxX]);
    wire [7:0] flashWd = (exec_r == X_ERASE) ? ERASED_BYTE
        : progByte;

    // Pending flag: a new command beats the clear on start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= cmdEvent | (pend_r & ~startX);
        end
    end

    // Self-timed engine: erase pass, program pass, settle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            exec_r <= X_IDLE;
            xOp_r <= 8'h00;
            xPage_r <= '0;
            xCnt_r <= FIRST_OFF;
            wait_r <= '0;
        end else begin
            case (exec_r)
                X_IDLE: begin
                    xCnt_r <= FIRST_OFF;
                    wait_r <= '0;
                    if (startX) begin
                        xOp_r <= op_r;
                        xPage_r <= cmdPage;
                        exec_r <= (op_r == OP_BUF1_PROG)
                            || (op_r == OP_BUF2_PROG) ? X_PROG : X_ERASE;
                    end
                end
                X_ERASE: begin
                    xCnt_r <= passEnd ? FIRST_OFF : 9'(xCnt_r + 9'h001);
                    if (passEnd) begin
                        exec_r <= xIsErase ? X_WAIT : X_PROG;
                    end
                end
                X_PROG: begin
                    xCnt_r <= passEnd ? FIRST_OFF : 9'(xCnt_r + 9'h001);
                    if (passEnd) begin
                        exec_r <= X_WAIT;
                    end
                end
                X_WAIT: begin
                    wait_r <= WW'(wait_r + 1'b1);
                    if (wait_r == WW'(OP_WAIT_CYCLES - 1)) begin
                        exec_r <= X_IDLE;
                    end
                end
                default: begin
                    exec_r <= X_IDLE;
                end
            endcase
        end
    end

    // Array writes from the engine only
    always_ff @(posedge clock) begin
        if (flashWe) begin
            flash[memIdxX] <= flashWd;
        end
    end

    // Busy covers the wait for select and the whole engine run
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= pend_r | (exec_r != X_IDLE) | startX;
        end
    end

    assign statusBusy = busy_r;
endmodule

/* design/sfpb_host.sv */
`timescale 1ns/1ps
module sfpb_host #(
    parameter int HALF_CYCLES = 4 // Clocks per serial clock half period
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic cmdStart, // Pulse: begin a frame
    input wire logic [7:0] cmdOp, // Opcode
    input wire logic [23:0] cmdAddr, // Three address bytes
    input wire logic [2:0] cmdDummy, // Dummy bytes after address
    input wire logic [15:0] cmdLen, // Data bytes after dummies
    input wire logic [7:0] wrData, // Next data byte to send
    output logic wrTake, // Pulse: wrData consumed
    output logic [7:0] rdData, // Byte received in data phase
    output logic rdValid, // Pulse: rdData new
    output logic cmdDone, // Pulse: frame finished
    output logic hostBusy, // Frame in progress
    sfpb_link_if.host lnk // Serial link
);
    import sfpb_pkg::*;

    localparam int HW = $clog2(HALF_CYCLES + 1);

    sfpb_host_e state_r;
    logic [HW-1:0] div_r;
    logic sck_r;
    logic csN_r;
    logic mosi_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [2:0] bit_r;
    logic [15:0] idx_r;
    logic [23:0] addr_r;
    logic [15:0] dataStart_r;
    logic [15:0] total_r;
    logic [7:0] rdData_r;
    logic rdValid_r;
    logic wrTake_r;
    logic done_r;
    logic busy_r;
    logic misoS1_r;
    logic misoS_r;

    wire halfEnd = (div_r == HW'(HALF_CYCLES - 1));
    wire [15:0] nextIdx = 16'(idx_r + 16'h0001);
    wire nextIsData = (nextIdx >= dataStart_r);
    // Byte source by position in the frame, MSB first
    wire [7:0] nextTx = (nextIdx == 16'h0001) ? addr_r[23:16]
        : (nextIdx == 16'h0002) ? addr_r[15:8]
        : (nextIdx == 16'h0003) ? addr_r[7:0]
        : nextIsData ? wrData : FILL_BYTE;
    wire [7:0] rxByte = {rx_r[6:0], misoS_r};
    wire lastByte = (nextIdx == total_r);

    // Returned data line passes two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            misoS1_r <= 1'b1;
            misoS_r <= 1'b1;
        end else begin
            misoS1_r <= lnk.miso;
            misoS_r <= misoS1_r;
        end
    end

    // Mode 0 framing: clock idles low, data set while low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= H_IDLE;
            div_r <= '0;
            sck_r <= 1'b0;
            csN_r <= 1'b1;
            mosi_r <= 1'b0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            bit_r <= 3'h0;
            idx_r <= 16'h0000;
            addr_r <= 24'h000000;
            dataStart_r <= HEAD_BYTES;
            total_r <= HEAD_BYTES;
            rdData_r <= 8'h00;
            rdValid_r <= 1'b0;
            wrTake_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            rdValid_r <= 1'b0;
            wrTake_r <= 1'b0;
            done_r <= 1'b0;
            div_r <= halfEnd ? '0 : HW'(div_r + 1'b1);
            case (state_r)
                H_IDLE: begin
                    div_r <= '0;
                    if (cmdStart) begin
                        csN_r <= 1'b0;
                        tx_r <= cmdOp;
                        mosi_r <= cmdOp[7];
                        addr_r <= cmdAddr;
                        bit_r <= 3'h0;
                        idx_r <= 16'h0000;
                        dataStart_r <= 16'(HEAD_BYTES + 16'(cmdDummy));
                        total_r <= 16'(HEAD_BYTES + 16'(cmdDummy) + cmdLen);
                        state_r <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (halfEnd) begin
                        sck_r <= 1'b1;
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (halfEnd) begin
                        sck_r <= 1'b0;
                        rx_r <= rxByte;
                        bit_r <= 3'(bit_r + 3'h1);
                        state_r <= H_LOW;
                        mosi_r <= tx_r[6];
                        tx_r <= {tx_r[6:0], 1'b0};
                        if (bit_r == LAST_BIT) begin
                            if (idx_r >= dataStart_r) begin
                                rdData_r <= rxByte;
                                rdValid_r <= 1'b1;
                            end
                            idx_r <= nextIdx;
                            tx_r <= nextTx;
                            mosi_r <= nextTx[7];
                            wrTake_r <= nextIsData & ~lastByte;
                            if (lastByte) begin
                                state_r <= H_TRAIL;
                            end
                        end
                    end
                end
                H_TRAIL: begin
                    if (halfEnd) begin
                        csN_r <= 1'b1;
                        state_r <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (halfEnd) begin
                        done_r <= 1'b1;
                        state_r <= H_IDLE;
                    end
                end
                default: begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // Busy flag registered for the user side
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_r != H_IDLE) | cmdStart;
        end
    end

    assign lnk.sck = sck_r;
    assign lnk.csN = csN_r;
    assign lnk.mosi = mosi_r;
    assign wrTake = wrTake_r;
    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign cmdDone = done_r;
    assign hostBusy = busy_r;
endmodule

/* design/sfpb_link_if.sv */
`timescale 1ns/1ps
interface sfpb_link_if;
    logic sck; // Serial clock from host
    logic csN; // Chip select, active low
    logic mosi; // Host to device data
    logic misoO; // Device output value
    logic misoOe; // Device output enable
    logic miso; // Resolved line, pulled high when undriven

    // Released line reads as the pull-up level
    assign miso = misoOe ? misoO : 1'b1;

    modport host (output sck, output csN, output mosi, input miso);
    modport dev (input sck, input csN, input mosi,
                 output misoO, output misoOe);
endinterface

/* design/sfpb_pkg.sv */
package sfpb_pkg;
    // Opcodes handled by this block
    localparam logic [7:0] OP_PAGE_READ = 8'hd2;
    localparam logic [7:0] OP_BUF1_READ_HI = 8'hd4;
    localparam logic [7:0] OP_BUF1_READ_LO = 8'hd1;
    localparam logic [7:0] OP_BUF2_READ_HI = 8'hd6;
    localparam logic [7:0] OP_BUF2_READ_LO = 8'hd3;
    localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
    localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
    localparam logic [7:0] OP_BUF1_PROG_ERASE = 8'h83;
    localparam logic [7:0] OP_BUF2_PROG_ERASE = 8'h86;
    localparam logic [7:0] OP_BUF1_PROG = 8'h88;
    localparam logic [7:0] OP_BUF2_PROG = 8'h89;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;

    // Array geometry
    localparam int PAGE_COUNT = 2048;
    localparam int PAGE_BYTES_STD = 264;
    localparam int PAGE_BYTES_BIN = 256;
    localparam int BUF_COUNT = 2;
    localparam logic [8:0] LAST_OFF_STD = 9'h107;
    localparam logic [8:0] LAST_OFF_BIN = 9'h0ff;
    localparam logic [8:0] FIRST_OFF = 9'h000;

    // Address field positions within the 24-bit address
    localparam int PAGE_LSB_STD = 9;
    localparam int PAGE_LSB_BIN = 8;
    localparam int PAGE_BITS = 11;

    // Framing counts
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] ADDR_BYTES = 3'h3;
    localparam logic [2:0] PAGE_READ_DUMMY = 3'h4;
    localparam logic [2:0] BUF_READ_DUMMY = 3'h1;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [15:0] HEAD_BYTES = 16'h0004;

    // System clock rate
    localparam int CLOCK_HZ = 10_000_000;

    // Device link state
    typedef enum logic [5:0] {
        L_OPCODE = 6'b000001,
        L_ADDR = 6'b000010,
        L_DUMMY = 6'b000100,
        L_READ = 6'b001000,
        L_WRITE = 6'b010000,
        L_IGNORE = 6'b100000
    } sfpb_link_e;

    // Device self-timed engine state
    typedef enum logic [3:0] {
        X_IDLE = 4'b0001,
        X_ERASE = 4'b0010,
        X_PROG = 4'b0100,
        X_WAIT = 4'b1000
    } sfpb_exec_e;

    // Host sequencer state
    typedef enum logic [5:0] {
        H_IDLE = 6'b000001,
        H_LEAD = 6'b000010,
        H_LOW = 6'b000100,
        H_HIGH = 6'b001000,
        H_TRAIL = 6'b010000,
        H_GAP = 6'b100000
    } sfpb_host_e;
endpackage

/* tb/sfpb_link_properties.sv */
`timescale 1ns/1ps
// Checks on the link between the two joined ends
module sfpb_link_properties (
    input wire logic clock, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic sck, // Serial clock
    input wire logic csN, // Chip select
    input wire logic mosi, // Host data
    input wire logic misoO, // Device bit
    input wire logic misoOe, // Device enable
    input wire logic miso, // Resolved line
    input wire logic statusBusy // Device busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Line released to the pull-up between frames
    a_out_released: assert property (csN |-> !misoOe && miso)
        else $error("output driven outside frame");
    a_idle_clk_low: assert property (csN |-> !sck)
        else $error("serial clock not idle low");
    a_lead_time: assert property ($fell(csN) |-> !sck [*4] ##1 sck)
        else $error("first rise misplaced");
    a_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("clock high time wrong");
    a_mosi_steady: assert property (sck |-> $stable(mosi))
        else $error("host data moved while clock high");
    a_miso_steady: assert property (sck |-> $stable(misoO))
        else $error("device data moved while clock high");
    a_busy_in_frame: assert property ($rose(statusBusy) |-> !csN)
        else $error("busy rose outside a frame");
    // Short wait parameter keeps the self-timed span under 600
    a_busy_bounded: assert property ($rose(csN) && statusBusy |->
        statusBusy [*8] ##[1:600] !statusBusy)
        else $error("busy span wrong");
    c_read: cover property ($rose(misoOe));
    c_busy: cover property ($fell(statusBusy));
    c_frame: cover property ($rose(csN));
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import sfpb_pkg::*;
    logic clock = 0, rst_n = 1, binaryPage = 0, cmdStart = 0;
    logic [7:0] cmdOp = 8'h00, wrData, rdData, wq [8], rq [$];
    logic [23:0] cmdAddr = 24'h000000;
    logic [2:0] cmdDummy = 3'h0;
    logic [15:0] cmdLen = 16'h0000;
    logic wrTake, rdValid, cmdDone, hostBusy, statusBusy;
    int n_fail = 0, cmp_count = 0, cyc = 0, wi = 0, seed = 32'h2e96;
    sfpb_link_if lnk ();
    sfpb_host sfpb_host_i (.clock(clock), .rst_n(rst_n),
        .cmdStart(cmdStart), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .cmdDummy(cmdDummy), .cmdLen(cmdLen), .wrData(wrData),
        .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid),
        .cmdDone(cmdDone), .hostBusy(hostBusy), .lnk(lnk.host));
    sfpb_device #(.PAGES(16), .OP_WAIT_CYCLES(4)) sfpb_device_i (
        .clock(clock), .rst_n(rst_n), .binaryPage(binaryPage),
        .statusBusy(statusBusy), .lnk(lnk.dev));
    sfpb_link_properties sfpb_link_properties_i (.clock(clock),
        .rst_n(rst_n), .sck(lnk.sck), .csN(lnk.csN), .mosi(lnk.mosi),
        .misoO(lnk.misoO), .misoOe(lnk.misoOe), .miso(lnk.miso),
        .statusBusy(statusBusy));
    // Next write byte is always ready, as the host demands
    assign wrData = wq[wi[2:0]];
    initial begin
        forever #50 clock = ~clock;
    end
    // Gather read bytes, step writes, cut a hang short
    always @(negedge clock) begin
        if (rdValid === 1'b1) rq.push_back(rdData);
        if (wrTake === 1'b1) wi++;
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            final_report;
        end
    end
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Start four bytes before the page end, so eight bytes wrap
    function automatic logic [23:0] pa(input int p);
        return binaryPage ? {5'h0, p[10:0], 8'hfc}
            : {4'h0, p[10:0], 9'h104};
    endfunction
    function automatic logic [7:0] exp_byte(input bit ff, input int i);
        return ff ? ERASED_BYTE : wq[i];
    endfunction
    // Only program and erase commands leave self-timed work
    function automatic logic exp_busy(input logic [7:0] op);
        return op inside {OP_BUF1_PROG_ERASE, OP_BUF2_PROG_ERASE,
            OP_BUF1_PROG, OP_BUF2_PROG, OP_PAGE_ERASE};
    endfunction
    // One whole frame, then wait out any self-timed work
    task automatic frame(input logic [7:0] op, input logic [23:0] a,
        input logic [2:0] dm, input logic [15:0] n);
        rq = {};
        wi = 0;
        {cmdOp, cmdAddr, cmdDummy, cmdLen} = {op, a, dm, n};
        cmdStart = 1;
        @(negedge clock) cmdStart = 0;
        cmp_count++;
        if (hostBusy !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED hostBusy exp 1 got %b", hostBusy);
        end
        while (cmdDone !== 1'b1) @(negedge clock);
        cmp_count++;
        if (statusBusy !== exp_busy(op)) begin
            n_fail++;
            $display("CHECK FAILED statusBusy exp %b got %b",
                exp_busy(op), statusBusy);
        end
        while (statusBusy !== 1'b0) @(negedge clock);
        @(negedge clock);
    endtask
    task automatic rdchk(input logic [7:0] op, input logic [23:0] a,
        input logic [2:0] dm, input bit ff);
        frame(op, a, dm, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            cmp_count++;
            if (rq[i] !== exp_byte(ff, i)) begin
                n_fail++;
                $display("CHECK FAILED byte %0d exp %h got %h", i,
                    exp_byte(ff, i), rq[i]);
            end
        end
    endtask
    initial begin
        // A real falling edge, so the serial-side resets fire too
        @(negedge clock) rst_n = 0;
        repeat (20) @(negedge clock);
        rst_n = 1;
        repeat (2) @(negedge clock);
        // Bit 0 picks the buffer, bit 1 the page size
        for (int m = 0; m < 4; m++) begin
            logic [7:0] wrOp, hiOp, loOp, pgOp;
            logic [23:0] bo, pg;
            wrOp = m[0] ? OP_BUF2_WRITE : OP_BUF1_WRITE;
            hiOp = m[0] ? OP_BUF2_READ_HI : OP_BUF1_READ_HI;
            loOp = m[0] ? OP_BUF2_READ_LO : OP_BUF1_READ_LO;
            pgOp = m[0] ? OP_BUF2_PROG : OP_BUF1_PROG_ERASE;
            binaryPage = m[1];
            bo = pa(0);
            pg = pa(m[0] + 3);
            foreach (wq[i]) wq[i] = 8'($random(seed));
            frame(wrOp, bo, 0, 8);
            rdchk(hiOp, bo, 1, 0);
            rdchk(loOp, bo, 1, 0);
            frame(OP_PAGE_ERASE, pg, 0, 0);
            rdchk(OP_PAGE_READ, pg, 4, 1);
            frame(pgOp, pg, 0, 0);
            rdchk(OP_PAGE_READ, pg, 4, 0);
            rdchk(hiOp, bo, 1, 0);
            $display("buffer %0d size %0d test done", m[0], m[1]);
        end
        final_report;
    end
endmodule
